// ### rtl/lock_fuse_params.svh
// Constants for the lock and fuse protection block
`ifndef LOCK_FUSE_PARAMS_SVH
`define LOCK_FUSE_PARAMS_SVH
// How it works
// - Six lock bits, 1 unprogrammed, 0 programmed; only chip erase or reset restores 1.
// - Lock byte bits 5..0 hold the boot, application and memory lock bits.
// - Memory lock mode 1 imposes no programming or verification limits.
// - Memory lock mode 2 refuses flash and EEPROM programming and fuse changes.
// - Mode 3 also refuses verification and locks the boot lock bits.
// - Application lock mode 1 leaves stores and loads to application free.
// - Application lock mode 2 refuses stores to application, loads allowed.
// - Application mode 3 refuses stores and boot-side loads of application.
// - Application mode 4 refuses boot-side loads of application, stores allowed.
// - Application modes 3,4 with boot vectors mask interrupts inside application.
// - Boot lock mode 1 leaves stores and loads to boot section free.
// - Boot lock mode 2 refuses stores into the boot section.
// - Boot mode 3 refuses boot stores and application-side loads of boot.
// - Boot mode 4 refuses application-side loads of boot, stores allowed.
// - Boot modes 3,4 with application vectors mask interrupts inside boot.
// - Fuses read 0 when programmed and 1 when unprogrammed.
// - Extended fuse byte: stage resets 7..5, level 4, boot size 2:1, vector 0.
// - Extended fuses default to 1 except boot size bits, which default 0.
// - Boot size 11,10,01,00 gives start 0xF80,0xF00,0xE00,0xC00.
// - Fuses latch at power-up and programming-mode entry; take effect on exit.
`define OFS_LOCK 8'h00
`define OFS_EFUSE 8'h04
`define OFS_EFUSE_ACT 8'h08
`define OFS_CTRL 8'h0C
`define OFS_STATUS 8'h10
`define LOCK_RESET 8'hFF
`define LOCK_UNUSED_MASK 8'hC0
`define EFUSE_RESET 8'hF9
`define BIT_BOOT_WR 5
`define BIT_BOOT_RD 4
`define BIT_APP_WR 3
`define BIT_APP_RD 2
`define BIT_MEM_B 1
`define BIT_MEM_A 0
`define BIT_RST_VEC 0
`define BIT_SZ_LO 1
`define BIT_SZ_HI 2
`define BIT_CTRL_PROG 0
`define BIT_CTRL_ERASE 1
`define BIT_STAT_REFUSED 0
`define BIT_STAT_PROG 1
`define BOOT_START_128 12'hF80
`define BOOT_START_256 12'hF00
`define BOOT_START_512 12'hE00
`define BOOT_START_1024 12'hC00
`endif

// ### rtl/lock_fuse_pkg.sv
// Types shared by the lock and fuse protection block
package lock_fuse_pkg;
  typedef struct packed {
    logic valid;
    logic isStore;
    logic [11:0] target;
    logic [11:0] pc;
  } spm_req_type;
  typedef struct packed {
    logic [7:0] lockReg;
    logic [7:0] efuseReg;
    logic [7:0] efuseActReg;
    logic progModeReg;
    logic refusedReg;
    logic [31:0] prdataReg;
    logic preadyReg;
    logic pslverrReg;
    logic extDoneReg;
    logic extGrantReg;
    logic spmDoneReg;
    logic spmGrantReg;
    logic intMaskReg;
  } state_type;
endpackage : lock_fuse_pkg

// ### rtl/lock_and_fuse_protection.sv
// Lock bits, extended fuse byte and the access checks they drive
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "lock_fuse_params.svh"
module lock_and_fuse_protection
  import lock_fuse_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External programming check
  input wire logic extValid,
  input wire logic extIsWrite,
  output logic extDone,
  output logic extGrant,
  // Core self-programming check
  input wire spm_req_type spmReq,
  output logic spmDone,
  output logic spmGrant,
  // Interrupt gating
  input wire logic [11:0] corePc,
  input wire logic vectorsInBoot,
  output logic intMask,
  // Latched fuse outputs
  output logic [7:0] efuseActive,
  output logic [7:0] lockActive
);

  logic [1:0] rstSync;
  logic rstSyncB;
  state_type stateReg;
  state_type stateNext;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstSyncB = rstSync[1];

  function automatic logic [11:0] bootStart(input logic [7:0] fuse);
    logic [1:0] sz;
    sz = {fuse[`BIT_SZ_HI], fuse[`BIT_SZ_LO]};
    case (sz)
      2'h3: bootStart = `BOOT_START_128;
      2'h2: bootStart = `BOOT_START_256;
      2'h1: bootStart = `BOOT_START_512;
      default: bootStart = `BOOT_START_1024;
    endcase
  endfunction : bootStart

  function automatic logic inBoot(input logic [11:0] addr,
                                  input logic [7:0] fuse);
    inBoot = (addr >= bootStart(fuse));
  endfunction : inBoot

  logic setupPhase;
  logic accessWrite;
  logic memMode1;
  logic memMode3;
  logic tgtBoot;
  logic pcBoot;
  logic curBoot;
  logic [7:0] wByte;

  always_comb begin
    stateNext = stateReg;
    setupPhase = psel && !penable;
    accessWrite = psel && penable && pwrite && stateReg.preadyReg;
    wByte = pwdata[7:0];
    memMode1 = stateReg.lockReg[`BIT_MEM_B] && stateReg.lockReg[`BIT_MEM_A];
    memMode3 = !stateReg.lockReg[`BIT_MEM_B] &&
               !stateReg.lockReg[`BIT_MEM_A];
    tgtBoot = inBoot(spmReq.target, stateReg.efuseActReg);
    pcBoot = inBoot(spmReq.pc, stateReg.efuseActReg);
    curBoot = inBoot(corePc, stateReg.efuseActReg);

    // Answer in the cycle after setup; zero wait states
    stateNext.preadyReg = setupPhase;
    stateNext.pslverrReg = 1'b0;
    if (setupPhase) begin
      stateNext.prdataReg = 32'h0;
      case (paddr)
        `OFS_LOCK: stateNext.prdataReg[7:0] = stateReg.lockReg;
        `OFS_EFUSE: stateNext.prdataReg[7:0] = stateReg.efuseReg;
        `OFS_EFUSE_ACT: stateNext.prdataReg[7:0] = stateReg.efuseActReg;
        `OFS_CTRL: stateNext.prdataReg[`BIT_CTRL_PROG] = stateReg.progModeReg;
        `OFS_STATUS: begin
          stateNext.prdataReg[`BIT_STAT_REFUSED] = stateReg.refusedReg;
          stateNext.prdataReg[`BIT_STAT_PROG] = stateReg.progModeReg;
        end
        default: stateNext.pslverrReg = 1'b1;
      endcase
    end

    if (accessWrite) begin
      case (paddr)
        `OFS_LOCK: begin
          // Programming only clears bits; unused bits stay at 1
          stateNext.lockReg = (stateReg.lockReg & wByte) |
                              `LOCK_UNUSED_MASK;
          if (memMode3) begin
            stateNext.lockReg[5:2] = stateReg.lockReg[5:2];
            if (wByte[5:2] != 4'hF) begin
              stateNext.refusedReg = 1'b1;
            end
          end
        end
        `OFS_EFUSE: begin
          if (memMode1) begin
            stateNext.efuseReg = wByte;
          end else begin
            stateNext.refusedReg = 1'b1;
          end
        end
        `OFS_CTRL: begin
          stateNext.progModeReg = wByte[`BIT_CTRL_PROG];
          // Chip erase and reset are the only paths back to unprogrammed locks
          if (wByte[`BIT_CTRL_ERASE] && stateReg.progModeReg) begin
            stateNext.lockReg = `LOCK_RESET;
          end
        end
        `OFS_STATUS: begin
          if (wByte[`BIT_STAT_REFUSED]) begin
            stateNext.refusedReg = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Fuses latch on mode entry and again on exit, so edits made
    // while programming reach the logic only afterwards
    if (stateNext.progModeReg != stateReg.progModeReg) begin
      stateNext.efuseActReg = stateNext.efuseReg;
    end

    // External programming and verification
    stateNext.extDoneReg = extValid;
    stateNext.extGrantReg = 1'b0;
    if (extValid) begin
      if (extIsWrite) begin
        stateNext.extGrantReg = memMode1;
      end else begin
        stateNext.extGrantReg = !memMode3;
      end
      if (!stateNext.extGrantReg) begin
        stateNext.refusedReg = 1'b1;
      end
    end

    // Self-programming stores and program-memory loads
    stateNext.spmDoneReg = spmReq.valid;
    stateNext.spmGrantReg = 1'b0;
    if (spmReq.valid) begin
      stateNext.spmGrantReg = 1'b1;
      if (spmReq.isStore) begin
        if (!tgtBoot && !stateReg.lockReg[`BIT_APP_RD]) begin
          stateNext.spmGrantReg = 1'b0;
        end
        if (tgtBoot && !stateReg.lockReg[`BIT_BOOT_RD]) begin
          stateNext.spmGrantReg = 1'b0;
        end
      end else begin
        if (pcBoot && !tgtBoot && !stateReg.lockReg[`BIT_APP_WR]) begin
          stateNext.spmGrantReg = 1'b0;
        end
        if (!pcBoot && tgtBoot && !stateReg.lockReg[`BIT_BOOT_WR]) begin
          stateNext.spmGrantReg = 1'b0;
        end
      end
      if (!stateNext.spmGrantReg) begin
        stateNext.refusedReg = 1'b1;
      end
    end

    // Vectors in the other section would leak control across the lock
    stateNext.intMaskReg =
      (vectorsInBoot && !curBoot && !stateReg.lockReg[`BIT_APP_WR]) ||
      (!vectorsInBoot && curBoot && !stateReg.lockReg[`BIT_BOOT_WR]);
  end

  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      stateReg.lockReg <= `LOCK_RESET;
      stateReg.efuseReg <= `EFUSE_RESET;
      stateReg.efuseActReg <= `EFUSE_RESET;
      stateReg.progModeReg <= 1'b0;
      stateReg.refusedReg <= 1'b0;
      stateReg.prdataReg <= 32'h0;
      stateReg.preadyReg <= 1'b0;
      stateReg.pslverrReg <= 1'b0;
      stateReg.extDoneReg <= 1'b0;
      stateReg.extGrantReg <= 1'b0;
      stateReg.spmDoneReg <= 1'b0;
      stateReg.spmGrantReg <= 1'b0;
      stateReg.intMaskReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign prdata = stateReg.prdataReg;
  assign pready = stateReg.preadyReg;
  assign pslverr = stateReg.pslverrReg;
  assign extDone = stateReg.extDoneReg;
  assign extGrant = stateReg.extGrantReg;
  assign spmDone = stateReg.spmDoneReg;
  assign spmGrant = stateReg.spmGrantReg;
  assign intMask = stateReg.intMaskReg;
  assign efuseActive = stateReg.efuseActReg;
  assign lockActive = stateReg.lockReg;

endmodule : lock_and_fuse_protection

// ### verif/lock_and_fuse_protection_sva.sv
// Port assertions for the lock and fuse protection block
`timescale 1ns/100ps
module lock_and_fuse_protection_sva
  import lock_fuse_pkg::*;
(
  // Clock, reset and APB
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Access checks
  input wire logic extValid,
  input wire logic extIsWrite,
  input wire logic extDone,
  input wire logic extGrant,
  input wire spm_req_type spmReq,
  input wire logic spmGrant,
  input wire logic [11:0] corePc,
  input wire logic vectorsInBoot,
  input wire logic intMask,
  // Latched bytes
  input wire logic [7:0] efuseActive,
  input wire logic [7:0] lockActive
);
  logic [11:0] bs;
  logic inBoot;
  logic storeOk;
  logic pcIn;
  assign pcIn = spmReq.pc >= bs;
  assign bs = efuseActive[2] ? (efuseActive[1] ? 12'hF80 : 12'hF00)
    : (efuseActive[1] ? 12'hE00 : 12'hC00);
  assign inBoot = spmReq.target >= bs;
  assign storeOk = inBoot ? lockActive[4] : lockActive[2];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; psel && penable && pready; endsequence
  property p_ready; s_setup |=> s_answer; endproperty
  a_ready: assert property (p_ready) else $error("late answer");
  property p_unmapped; s_setup ##0 paddr > 8'h10 |=> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slverr");
  property p_ext_done; extValid |=> extDone; endproperty
  a_ext_done: assert property (p_ext_done) else $error("no done");
  property p_ext_prog;
    extValid && extIsWrite && lockActive[1:0] != 2'b11 |=> !extGrant;
  endproperty
  a_ext_prog: assert property (p_ext_prog) else $error("prog open");
  property p_ext_verify;
    extValid && !extIsWrite && lockActive[1:0] == 2'b00 |=> !extGrant;
  endproperty
  a_ext_verify: assert property (p_ext_verify) else $error("read open");
  property p_store; spmReq.valid && spmReq.isStore && !storeOk |=> !spmGrant;
  endproperty
  a_store: assert property (p_store) else $error("store open");
  property p_load;
    spmReq.valid && !spmReq.isStore && pcIn && !inBoot && !lockActive[3]
      |=> !spmGrant;
  endproperty
  a_load: assert property (p_load) else $error("load open");
  property p_mask_app;
    !lockActive[3] && vectorsInBoot && corePc < bs |=> intMask;
  endproperty
  a_mask_app: assert property (p_mask_app) else $error("no mask");
  property p_mask_boot;
    !lockActive[5] && !vectorsInBoot && corePc >= bs |=> intMask;
  endproperty
  a_mask_boot: assert property (p_mask_boot) else $error("no mask");
endmodule : lock_and_fuse_protection_sva
bind lock_and_fuse_protection lock_and_fuse_protection_sva
  lock_and_fuse_protection_sva_i (.*);

// ### verif/access_source.sv
// Core and programmer stand-in that launches checked accesses
`timescale 1ns/100ps
module access_source
  import lock_fuse_pkg::*;
(
  // Clock and bench commands
  input wire logic mclk,
  input wire spm_req_type spmCmd,
  input wire logic extCmd,
  input wire logic extWrCmd,
  input wire logic vecCmd,
  // Requests toward the block
  output spm_req_type spmReq,
  output logic extValid,
  output logic extIsWrite,
  output logic [11:0] corePc,
  output logic vectorsInBoot
);
  spm_req_type spmReg = '0;
  logic [14:0] ctlReg = 15'h0000;
  // Idle qualifiers wander so a stale value is never trusted
  always @(posedge mclk) begin
    spmReg <= spmCmd.valid ? spmCmd : {1'b0, ~spmReg[24:0]};
    ctlReg <= {extCmd, extCmd ? extWrCmd : ~ctlReg[13], vecCmd, spmCmd.pc};
  end
  assign spmReq = spmReg;
  assign {extValid, extIsWrite, vectorsInBoot, corePc} = ctlReg;
endmodule : access_source

// ### verif/lock_and_fuse_protection_test.sv
// Self-checking bench for the lock and fuse protection block
`timescale 1ns/100ps
module lock_and_fuse_protection_test
  import lock_fuse_pkg::*;
;
  logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, extCmd = 1'b0, extWrCmd = 1'b0, vecCmd = 1'b0;
  logic pready, pslverr, extDone, extGrant, spmDone, spmGrant, intMask;
  logic extValid, extIsWrite, vectorsInBoot;
  logic [7:0] paddr = 8'h00, efuseActive, lockActive, lk;
  logic [11:0] corePc, bs = 12'hC00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  spm_req_type spmCmd = '0, spmReq;
  logic [32:0] apbQ[$];
  logic [1:0] accQ[$];
  int nFail = 0, checksDone = 0, seed = 47;
  always #20 mclk = ~mclk;
  lock_and_fuse_protection lock_and_fuse_protection_i (.*);
  access_source access_source_i (.*);
  task automatic cmpApb(input logic [32:0] e, g);
    checksDone++;
    if (g !== e) begin
      nFail++;
      $display("Error %0t exp %h got %h", $time, e, g);
    end
  endtask : cmpApb
  task automatic cmpAcc(input logic [1:0] e, g);
    checksDone++;
    if (g !== e) begin
      nFail++;
      $display("Error %0t exp %h got %h", $time, e, g);
    end
  endtask : cmpAcc
  task automatic printVerdict;
    if (nFail == 0 && checksDone > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : printVerdict
  task automatic apb(input logic w, input logic [7:0] a, d,
    input logic [32:0] e);
    if (!w) apbQ.push_back(e);
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do @(posedge mclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask : apb
  // Expected grant and mask, worked out from the lock byte the bench wrote
  task automatic acc(input logic st, input logic [11:0] tg, pc,
    input logic vb);
    logic tb, pb;
    tb = tg >= bs;
    pb = pc >= bs;
    @(posedge mclk);
    spmCmd <= '{1'b1, st, tg, pc};
    vecCmd <= vb;
    accQ.push_back({st ? (tb ? lk[4] : lk[2]) :
      !(pb && !tb && !lk[3]) && !(!pb && tb && !lk[5]),
      (!lk[3] && vb && !pb) || (!lk[5] && !vb && pb)});
  endtask : acc
  task automatic ext(input logic w, ok);
    @(posedge mclk);
    {extCmd, extWrCmd} <= {1'b1, w};
    accQ.push_back({ok, 1'b0});
    @(posedge mclk);
    extCmd <= 1'b0;
  endtask : ext
  always @(posedge mclk) begin
    logic [32:0] e;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = apbQ.pop_front();
      cmpApb(e, {pslverr, e[32] ? e[31:0] : prdata});
    end
    if (spmDone === 1'b1 || extDone === 1'b1)
      cmpAcc(accQ.pop_front(), {spmDone ? spmGrant : extGrant, intMask});
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    apb(1'b0, 8'h00, 8'h00, 33'hFF);
    apb(1'b0, 8'h08, 8'h00, 33'hF9);
    apb(1'b0, 8'h14, 8'h00, {1'b1, 32'h0});
    apb(1'b1, 8'h04, 8'hFF, 33'h0);
    apb(1'b0, 8'h08, 8'h00, 33'hF9);
    apb(1'b1, 8'h0C, 8'h01, 33'h0);
    apb(1'b0, 8'h08, 8'h00, 33'hFF);
    bs = 12'hF80;
    for (int i = 0; i < 16; i++) begin
      lk = {2'b11, i[3:0], 2'b11};
      apb(1'b1, 8'h0C, 8'h03, 33'h0);
      apb(1'b1, 8'h00, lk, 33'h0);
      apb(1'b0, 8'h00, 8'h00, {25'h0, lk});
      acc(1'b1, 12'hF7F, 12'hF80, 1'b1);
      acc(1'b0, 12'hF80, 12'hF7F, 1'b0);
      repeat (6) begin
        r = $random(seed);
        acc(r[0], {r[1] ? 5'h1F : r[6:2], r[13:7]},
          {r[14] ? 5'h1F : r[19:15], r[26:20]}, r[27]);
      end
      @(posedge mclk) spmCmd <= '0;
    end
    apb(1'b1, 8'h0C, 8'h03, 33'h0);
    lk = 8'hFF;
    // Memory lock bits go last so nothing earlier is locked out
    for (int m = 3; m >= 0; m--) begin
      if (m == 1) continue;
      apb(1'b1, 8'h00, {6'h3F, 2'(m)}, 33'h0);
      ext(1'b1, m == 3);
      ext(1'b0, m != 0);
    end
    apb(1'b1, 8'h04, 8'h00, 33'h0);
    apb(1'b0, 8'h04, 8'h00, 33'hFF);
    apb(1'b0, 8'h10, 8'h00, 33'h3);
    apb(1'b1, 8'h00, 8'hFF, 33'h0);
    apb(1'b0, 8'h00, 8'h00, 33'hFC);
    printVerdict;
  end
  // The whole run needs well under 2000 cycles
  initial begin
    #200000;
    nFail++;
    printVerdict;
  end
endmodule : lock_and_fuse_protection_test
